// [rtl/tic_pkg.sv]
// Package: register map, field layout and constants of the interval counter
package tic_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_TARGET = 5'h04;
    localparam logic [4:0] OFS_FRACTION = 5'h08;
    localparam logic [4:0] OFS_SECOND = 5'h0c;
    localparam logic [4:0] OFS_MINUTE = 5'h10;
    localparam logic [4:0] OFS_HOUR = 5'h14;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h18;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h1c;

    // ------------------------------------------------------------------
    // Reset values and counting limits
    // ------------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam logic [7:0] FRACTION_LAST = 8'h7f;
    localparam logic [7:0] SECOND_LAST = 8'h3b;
    localparam logic [7:0] MINUTE_LAST = 8'h3b;
    localparam logic [7:0] HOUR_LAST = 8'h17;
    localparam logic [0:0] IRQ_BIT_MATCH = 1'h0;

    // Slow clock rate and fractional-second rate
    localparam int SLOW_CLOCK_HZ = 32768;
    localparam int FRACTION_HZ = 128;
    localparam int PRESCALE_COUNT = SLOW_CLOCK_HZ / FRACTION_HZ;

    // ------------------------------------------------------------------
    // Timebase select codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TB_FRACTION,
        TB_SECOND,
        TB_MINUTE,
        TB_HOUR
    } timebase_t;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic reserved;
        logic must_be_one;
        timebase_t timebase_select;
        logic single_interval;
        logic interval_match_flag;
        logic interval_enable;
        logic time_chain_run;
    } control_t;

endpackage : tic_pkg

// [rtl/time_interval_counter.sv]
// Time interval counter: time-of-day chain, interval counter, Avalon-MM slave
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns

// Behaviour
// - Counting runs from the 32.768 kHz tick, independent of processor power-down.
// - Control bit 0 cleared stops the time-of-day chain.
// - Control bit 1 enables interval counter; cleared, it disables and clears count.
// - Control bits 5:4 pick fraction, second, minute or hour unit, ascending.
// - Interval counter advances once per increment of the selected chain register.
// - Count equal to target sets flag in control bit 2 and interrupts if enabled.
// - Control bit 3 zero reloads and restarts; one times a single interval.
// - Fraction wraps after 127 and carries; second and minute carry likewise; hour wraps after 23 with no carry.
// - Fraction, second, minute and hour registers are writable to preset time.
// - Interval interrupt is delivered only when its enable is set.
// - Match during power-down with interval counter enabled and interrupt unmasked produces a wake-up.
// - Target register holds an 8-bit interval value.
module time_interval_counter
    import tic_pkg::*;
#(
    parameter int PRESCALE_W = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow_clock_tick,
    input wire logic power_down,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic wake_up
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if ((1 << PRESCALE_W) != PRESCALE_COUNT)
    begin : g_bad_prescale
        $error("Prescaler width must divide the slow clock down to 128 Hz");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    control_t control_q;
    logic [7:0] target_q;
    logic [7:0] fraction_q;
    logic [7:0] second_q;
    logic [7:0] minute_q;
    logic [7:0] hour_q;
    logic [7:0] interval_q;
    logic interval_stopped_q;
    logic irq_status_q;
    logic irq_mask_q;
    logic tick_prev_q;
    logic [PRESCALE_W-1:0] prescale_q;
    logic read_ack_q;
    logic [31:0] readdata_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic wr_low;
    logic wr_control;
    logic wr_target;
    logic wr_fraction;
    logic wr_second;
    logic wr_minute;
    logic wr_hour;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic [7:0] wbyte;

    assign wr_low = avs_write && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign wr_control = wr_low && (avs_address == OFS_CONTROL);
    assign wr_target = wr_low && (avs_address == OFS_TARGET);
    assign wr_fraction = wr_low && (avs_address == OFS_FRACTION);
    assign wr_second = wr_low && (avs_address == OFS_SECOND);
    assign wr_minute = wr_low && (avs_address == OFS_MINUTE);
    assign wr_hour = wr_low && (avs_address == OFS_HOUR);
    assign wr_irq_status = wr_low && (avs_address == OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_low && (avs_address == OFS_IRQ_MASK);

    // Writes complete at once; reads take one wait cycle for registered data
    assign avs_waitrequest = avs_read && !read_ack_q;
    assign avs_readdata = readdata_q;

    // ------------------------------------------------------------------
    // Slow tick and prescaler
    // ------------------------------------------------------------------
    logic slow_edge;
    logic fraction_tick;

    // Only the rising edge of the slow clock counts, so mclk may run at any rate fast enough to sample each slow clock level
    assign slow_edge = slow_clock_tick && !tick_prev_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tick_prev_q <= 1'b0;
        end
        else
        begin
            tick_prev_q <= slow_clock_tick;
        end
    end

    // Prescaler is not gated by power_down; only chain run stops it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prescale_q <= '0;
        end
        else if (!control_q.time_chain_run)
        begin
            prescale_q <= '0;
        end
        else if (slow_edge)
        begin
            prescale_q <= prescale_q + 1'b1;
        end
    end

    assign fraction_tick = slow_edge && control_q.time_chain_run && (&prescale_q);

    // ------------------------------------------------------------------
    // Time-of-day chain
    // ------------------------------------------------------------------
    logic fraction_ovf;
    logic second_ovf;
    logic minute_ovf;
    logic hour_ovf;

    assign fraction_ovf = fraction_tick && (fraction_q == FRACTION_LAST);
    assign second_ovf = fraction_ovf && (second_q == SECOND_LAST);
    assign minute_ovf = second_ovf && (minute_q == MINUTE_LAST);
    assign hour_ovf = minute_ovf && (hour_q == HOUR_LAST);

    // A software write wins over a carry landing in the same cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fraction_q <= 8'h00;
        end
        else if (wr_fraction)
        begin
            fraction_q <= wbyte & FRACTION_LAST;
        end
        else if (fraction_ovf)
        begin
            fraction_q <= 8'h00;
        end
        else if (fraction_tick)
        begin
            fraction_q <= fraction_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            second_q <= 8'h00;
        end
        else if (wr_second)
        begin
            second_q <= wbyte;
        end
        else if (second_ovf)
        begin
            second_q <= 8'h00;
        end
        else if (fraction_ovf)
        begin
            second_q <= second_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            minute_q <= 8'h00;
        end
        else if (wr_minute)
        begin
            minute_q <= wbyte;
        end
        else if (minute_ovf)
        begin
            minute_q <= 8'h00;
        end
        else if (second_ovf)
        begin
            minute_q <= minute_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hour_q <= 8'h00;
        end
        else if (wr_hour)
        begin
            hour_q <= wbyte;
        end
        else if (hour_ovf)
        begin
            hour_q <= 8'h00;
        end
        else if (minute_ovf)
        begin
            hour_q <= hour_q + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Interval counter
    // ------------------------------------------------------------------
    logic base_tick;
    logic [7:0] interval_next;
    logic match;

    always_comb
    begin
        case (control_q.timebase_select)
            TB_FRACTION: base_tick = fraction_tick;
            TB_SECOND: base_tick = fraction_ovf;
            TB_MINUTE: base_tick = second_ovf;
            TB_HOUR: base_tick = minute_ovf;
            default: base_tick = 1'b0;
        endcase
    end

    assign interval_next = interval_q + 8'h01;
    assign match = base_tick && control_q.interval_enable && !interval_stopped_q
        && (interval_next == target_q);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            interval_q <= 8'h00;
            interval_stopped_q <= 1'b0;
        end
        else if (!control_q.interval_enable)
        begin
            interval_q <= 8'h00;
            interval_stopped_q <= 1'b0;
        end
        else if (match && control_q.single_interval)
        begin
            interval_q <= interval_next;
            interval_stopped_q <= 1'b1;
        end
        else if (match)
        begin
            interval_q <= 8'h00;
        end
        else if (base_tick && !interval_stopped_q)
        begin
            interval_q <= interval_next;
        end
    end

    // ------------------------------------------------------------------
    // Target and control registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            target_q <= TARGET_RESET;
        end
        else if (wr_target)
        begin
            target_q <= wbyte;
        end
    end

    // Flag follows the written bit unless a match arrives: set beats clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            control_q <= control_t'(CONTROL_RESET);
        end
        else
        begin
            if (wr_control)
            begin
                control_q.must_be_one <= wbyte[6];
                control_q.timebase_select <= timebase_t'(wbyte[5:4]);
                control_q.single_interval <= wbyte[3];
                control_q.interval_enable <= wbyte[1];
                control_q.time_chain_run <= wbyte[0];
            end
            if (match)
            begin
                control_q.interval_match_flag <= 1'b1;
            end
            else if (wr_control)
            begin
                control_q.interval_match_flag <= wbyte[2];
            end
            control_q.reserved <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_q <= 1'b0;
        end
        else if (match)
        begin
            irq_status_q <= 1'b1;
        end
        else if (wr_irq_status && wbyte[IRQ_BIT_MATCH])
        begin
            irq_status_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_q <= 1'b0;
        end
        else if (wr_irq_mask)
        begin
            irq_mask_q <= wbyte[IRQ_BIT_MATCH];
        end
    end

    assign irq = irq_status_q && irq_mask_q;

    // Wake only while powered down and the interval counter stays enabled
    assign wake_up = irq && power_down && control_q.interval_enable;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] rbyte;

    always_comb
    begin
        case (avs_address)
            OFS_CONTROL: rbyte = control_q;
            OFS_TARGET: rbyte = target_q;
            OFS_FRACTION: rbyte = fraction_q;
            OFS_SECOND: rbyte = second_q;
            OFS_MINUTE: rbyte = minute_q;
            OFS_HOUR: rbyte = hour_q;
            OFS_IRQ_STATUS: rbyte = {7'h00, irq_status_q};
            OFS_IRQ_MASK: rbyte = {7'h00, irq_mask_q};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            read_ack_q <= 1'b0;
        end
        else
        begin
            read_ack_q <= avs_read && !read_ack_q;
        end
    end

    // Data captured in the wait cycle stands through the completing edge
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            readdata_q <= 32'h0000_0000;
        end
        else if (avs_read && !read_ack_q)
        begin
            readdata_q <= {24'h00_0000, rbyte};
        end
    end

endmodule : time_interval_counter

// [bench/time_interval_counter_chk.sv]
// Checker: port-level assertions for the time interval counter
`timescale 1ns/1ns
module time_interval_counter_chk
    import tic_pkg::*;
#(
    parameter int PRESCALE_W = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow_clock_tick,
    input wire logic power_down,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic wake_up
);
    logic mask_q;
    logic enable_q;
    logic rd_done;
    logic wr_ok;
    assign rd_done = avs_read && !avs_waitrequest;
    assign wr_ok = avs_write && avs_byteenable[0];

    // Shadow copies of software-only bits
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            mask_q <= 1'b0;
        else if (wr_ok && avs_address == OFS_IRQ_MASK)
            mask_q <= avs_writedata[0];

    always_ff @(posedge mclk or posedge rst)
        if (rst)
            enable_q <= 1'b0;
        else if (wr_ok && avs_address == OFS_CONTROL)
            enable_q <= avs_writedata[1];

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_irq_mask_gate: assert property (!mask_q |-> !irq)
        else $error("irq raised while masked");
    a_wake_needs_cause: assert property (wake_up |-> power_down && irq && enable_q)
        else $error("wake_up without cause");
    a_wake_when_due: assert property (irq && power_down && enable_q |-> wake_up)
        else $error("wake_up missing");
    a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    a_high_lanes_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_unmapped_zero: assert property (rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (rd_done && avs_address == OFS_CONTROL |-> !avs_readdata[7])
        else $error("reserved control bit set");
    a_enable_readback: assert property (rd_done && avs_address == OFS_CONTROL |-> avs_readdata[1] == enable_q)
        else $error("enable bit readback wrong");
    a_mask_readback: assert property (rd_done && avs_address == OFS_IRQ_MASK |-> avs_readdata[0] == mask_q)
        else $error("mask readback wrong");

    c_read: cover property (rd_done);
    c_irq: cover property ($rose(irq));
    c_wake: cover property ($rose(wake_up));
endmodule : time_interval_counter_chk

bind time_interval_counter time_interval_counter_chk #(.PRESCALE_W(PRESCALE_W)) i_chk (.*);

// [bench/time_interval_counter_tb.sv]
// Testbench: register-level tests of the time interval counter
`timescale 1ns/1ns
`define CHK(nm, e, g) cmp(nm, e, g)
module time_interval_counter_tb;
    import tic_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic slow_clock_tick = 1'b0;
    logic power_down = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic wake_up;
    int n_errors = 0;
    int check_count = 0;

    always #4 mclk = ~mclk;

    time_interval_counter i_time_interval_counter (.*);

    // ------------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : cmp

    // Waitrequest and read data are taken at the rising edge that ends the request
    task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] wd,
        output logic [31:0] d);
        int t;
        t = 0;
        d = 32'h0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, wd};
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && t < 20)
        begin
            t++;
            @(posedge mclk);
        end
        `CHK("waitrequest", 32'h0, avs_waitrequest);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [4:0] a, input logic [7:0] wd);
        logic [31:0] d;
        xfer(1'b1, a, wd, d);
    endtask : wr

    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] d;
        xfer(1'b0, a, 8'h00, d);
        `CHK($sformatf("register %h", a), {24'h0, e}, d);
    endtask : rchk

    // One fraction tick is 256 rising slow edges
    task automatic ticks(input int n);
        repeat (n * 256)
        begin
            @(posedge mclk);
            slow_clock_tick <= 1'b1;
            @(posedge mclk);
            slow_clock_tick <= 1'b0;
        end
        repeat (4) @(posedge mclk);
    endtask : ticks

    task automatic run_case(input logic [7:0] ctl, input int n, input logic hit);
        if (ctl != 8'h00)
            wr(OFS_CONTROL, ctl);
        wr(OFS_IRQ_STATUS, 8'h01);
        ticks(n);
        rchk(OFS_IRQ_STATUS, {7'h0, hit});
    endtask : run_case

    task automatic close_out();
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic hit;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++)
            rchk(5'(a * 4), 8'h00);
        rchk(5'h02, 8'h00);
        wr(OFS_TARGET, 8'ha5);
        rchk(OFS_TARGET, 8'ha5);
        avs_byteenable <= 4'he;
        wr(OFS_TARGET, 8'h3c);
        avs_byteenable <= 4'hf;
        rchk(OFS_TARGET, 8'ha5);
        wr(OFS_FRACTION, 8'hff);
        rchk(OFS_FRACTION, 8'h7f);
        wr(OFS_CONTROL, 8'hff);
        rchk(OFS_CONTROL, 8'h7f);
        wr(OFS_CONTROL, 8'h41);
        wr(OFS_FRACTION, 8'h7f);
        wr(OFS_SECOND, 8'h3b);
        wr(OFS_MINUTE, 8'h3b);
        wr(OFS_HOUR, 8'h17);
        wr(OFS_CONTROL, 8'h41);
        ticks(1);
        for (int a = 2; a < 6; a++)
            rchk(5'(a * 4), 8'h00);
        ticks(1);
        rchk(OFS_FRACTION, 8'h01);
        wr(OFS_CONTROL, 8'h40);
        ticks(1);
        rchk(OFS_FRACTION, 8'h01);
        // Each timebase against each depth of carry
        power_down <= 1'b1;
        wr(OFS_IRQ_MASK, 8'h01);
        for (int tb = 0; tb < 4; tb++)
            for (int lv = 0; lv < 4; lv++)
            begin
                hit = (tb <= lv);
                wr(OFS_CONTROL, 8'h41);
                wr(OFS_IRQ_STATUS, 8'h01);
                wr(OFS_FRACTION, (lv >= 1) ? 8'h7f : 8'h00);
                wr(OFS_SECOND, (lv >= 2) ? 8'h3b : 8'h00);
                wr(OFS_MINUTE, (lv >= 3) ? 8'h3b : 8'h00);
                wr(OFS_TARGET, 8'h01);
                wr(OFS_CONTROL, 8'h43 | 8'(tb << 4));
                ticks(1);
                rchk(OFS_IRQ_STATUS, {7'h0, hit});
                rchk(OFS_CONTROL, 8'h43 | 8'(tb << 4) | (hit ? 8'h04 : 8'h00));
                `CHK("irq", {31'h0, hit}, irq);
                `CHK("wake_up", {31'h0, hit}, wake_up);
            end
        wr(OFS_IRQ_MASK, 8'h00);
        @(posedge mclk);
        `CHK("irq", 32'h0, irq);
        `CHK("wake_up", 32'h0, wake_up);
        wr(OFS_IRQ_STATUS, 8'h01);
        rchk(OFS_IRQ_STATUS, 8'h00);
        wr(OFS_CONTROL, 8'h73);
        rchk(OFS_CONTROL, 8'h73);
        power_down <= 1'b0;
        // Enable clearing, reload and single interval
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_TARGET, 8'h02);
        wr(OFS_CONTROL, 8'h40);
        run_case(8'h43, 1, 1'b0);
        run_case(8'h41, 0, 1'b0);
        run_case(8'h43, 1, 1'b0);
        run_case(8'h00, 1, 1'b1);
        run_case(8'h00, 2, 1'b1);
        run_case(8'h4b, 2, 1'b1);
        run_case(8'h00, 4, 1'b0);
        run_case(8'h49, 0, 1'b0);
        run_case(8'h4b, 2, 1'b1);
        close_out();
    end

    initial
    begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule : time_interval_counter_tb
